/* rtl/spmlc_bank.sv */
// status pin drive and output silence level register bank
//
// Summary of operation
// - bit 5: spike limit on status pin 1
// - bit 4: spike limit on status pin 0
// - bit 1 set: status pin 1 open-drain
// - bit 0 set: status pin 0 open-drain
// - bits 7:6 select out3 silenced drive, reset 1
// - bits 5:4 select out2 silenced drive, reset 1
// - level picks drive; enable bit decides silencing
// - differential: bypass, vcm, high, rail/ground
// - single-ended: bypass, n low, p low, both low
// - differential code 3 rail on p, ground on n
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`include "spmlc_consts.svh"

module spmlc_bank (
   input  wire logic                    i_clock,    // 250 MHz
   input  wire logic                    i_nrst,     // async, active low
   input  wire logic [`SPMLC_ADDR_W-1:0] i_addr,    // register address
   input  wire logic [7:0]              i_wdata,    // write data
   input  wire logic                    i_wr,       // write strobe
   input  wire logic                    i_rd,       // read strobe
   output logic      [7:0]              o_rdata,    // read data, next cycle
   input  wire logic [1:0]              i_status,   // status levels to pins
   input  wire logic                    i_out2_se,  // out2 single-ended mode
   input  wire logic                    i_out3_se,  // out3 single-ended mode
   output logic      [1:0]              o_status,   // status pin data
   output logic      [1:0]              o_status_oe_n, // pin enable, low=drive
   output logic      [1:0]              o_status_spike_lim, // slow edge
   output spmlc_pkg::spmlc_drv_t        o_out2_p,   // out2 p node action
   output spmlc_pkg::spmlc_drv_t        o_out2_n,   // out2 n node action
   output spmlc_pkg::spmlc_drv_t        o_out3_p,   // out3 p node action
   output spmlc_pkg::spmlc_drv_t        o_out3_n    // out3 n node action
);

   spmlc_pkg::spmlc_state_t s_q;
   spmlc_pkg::spmlc_state_t s_d;

   // -----------------------------------------------------------------
   // node action from level code and mode
   // -----------------------------------------------------------------
   function automatic logic [5:0] drv_of(input logic en,
                                         input logic se,
                                         input logic [1:0] lvl);
      spmlc_pkg::spmlc_drv_t p;
      spmlc_pkg::spmlc_drv_t n;
      p = spmlc_pkg::SPMLC_DRV_RUN;
      n = spmlc_pkg::SPMLC_DRV_RUN;
      // only the enable bit silences; level only shapes it
      if (en) begin
         unique case (spmlc_pkg::spmlc_lvl_t'(lvl))
            spmlc_pkg::SPMLC_LVL_BYPASS: begin
               p = spmlc_pkg::SPMLC_DRV_RUN;
               n = spmlc_pkg::SPMLC_DRV_RUN;
            end
            spmlc_pkg::SPMLC_LVL_ONE: begin
               if (se) begin
                  n = spmlc_pkg::SPMLC_DRV_LOW;
               end else begin
                  p = spmlc_pkg::SPMLC_DRV_VCM;
                  n = spmlc_pkg::SPMLC_DRV_VCM;
               end
            end
            spmlc_pkg::SPMLC_LVL_TWO: begin
               if (se) begin
                  p = spmlc_pkg::SPMLC_DRV_LOW;
               end else begin
                  p = spmlc_pkg::SPMLC_DRV_HIGH;
                  n = spmlc_pkg::SPMLC_DRV_HIGH;
               end
            end
            spmlc_pkg::SPMLC_LVL_THREE: begin
               if (se) begin
                  p = spmlc_pkg::SPMLC_DRV_LOW;
                  n = spmlc_pkg::SPMLC_DRV_LOW;
               end else begin
                  p = spmlc_pkg::SPMLC_DRV_RAIL;
                  n = spmlc_pkg::SPMLC_DRV_LOW;
               end
            end
         endcase
      end
      drv_of = {p, n};
   endfunction

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      logic [5:0] d2;
      logic [5:0] d3;
      d2 = '0;
      d3 = '0;
      s_d = s_q;
      if (i_wr) begin
         unique case (i_addr)
            `SPMLC_OFF_STAT_DRV:
               // reserved 7:6 read zero; 3:2 stored as rw
               s_d.stat_drv = i_wdata & `SPMLC_STAT_RW_MASK;
            `SPMLC_OFF_SIL_LVL_A:
               s_d.sil_lvl_a = i_wdata;
            `SPMLC_OFF_SIL_CTRL:
               s_d.sil_ctrl = {6'h00, i_wdata[1:0]};
            default: ;
         endcase
      end
      s_d.rdata = 8'h00;
      if (i_rd) begin
         unique case (i_addr)
            `SPMLC_OFF_STAT_DRV:  s_d.rdata = s_q.stat_drv;
            `SPMLC_OFF_SIL_LVL_A: s_d.rdata = s_q.sil_lvl_a;
            `SPMLC_OFF_SIL_CTRL:  s_d.rdata = s_q.sil_ctrl;
            default:              s_d.rdata = 8'h00;
         endcase
      end
      // pin drive: open-drain releases high, push-pull drives both
      s_d.st_o = i_status;
      s_d.st_oe_n[0] = s_q.stat_drv[`SPMLC_BIT_P0_OD] & i_status[0];
      s_d.st_oe_n[1] = s_q.stat_drv[`SPMLC_BIT_P1_OD] & i_status[1];
      s_d.st_spike[0] = s_q.stat_drv[`SPMLC_BIT_P0_SPIKE];
      s_d.st_spike[1] = s_q.stat_drv[`SPMLC_BIT_P1_SPIKE];
      d2 = drv_of(s_q.sil_ctrl[0], i_out2_se,
                  s_q.sil_lvl_a[`SPMLC_OUT2_LVL_HI:`SPMLC_OUT2_LVL_LO]);
      d3 = drv_of(s_q.sil_ctrl[1], i_out3_se,
                  s_q.sil_lvl_a[`SPMLC_OUT3_LVL_HI:`SPMLC_OUT3_LVL_LO]);
      s_d.o2_p = d2[5:3];
      s_d.o2_n = d2[2:0];
      s_d.o3_p = d3[5:3];
      s_d.o3_n = d3[2:0];
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         s_q <= '0;
         s_q.stat_drv  <= `SPMLC_RST_STAT_DRV;
         s_q.sil_lvl_a <= `SPMLC_RST_SIL_LVL_A;
         s_q.sil_ctrl  <= `SPMLC_RST_SIL_CTRL;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata            = s_q.rdata;
   assign o_status           = s_q.st_o;
   assign o_status_oe_n      = s_q.st_oe_n;
   assign o_status_spike_lim = s_q.st_spike;
   assign o_out2_p           = spmlc_pkg::spmlc_drv_t'(s_q.o2_p);
   assign o_out2_n           = spmlc_pkg::spmlc_drv_t'(s_q.o2_n);
   assign o_out3_p           = spmlc_pkg::spmlc_drv_t'(s_q.o3_p);
   assign o_out3_n           = spmlc_pkg::spmlc_drv_t'(s_q.o3_n);

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   spike1_write_a: assert property (
      i_wr && i_addr == `SPMLC_OFF_STAT_DRV ##2 1
      |-> o_status_spike_lim[1] == $past(i_wdata[5], 2))
      else $error("pin1 spike limit not following write");
   spike0_write_a: assert property (
      i_wr && i_addr == `SPMLC_OFF_STAT_DRV ##2 1
      |-> o_status_spike_lim[0] == $past(i_wdata[4], 2))
      else $error("pin0 spike limit not following write");
   pin1_od_a: assert property (
      s_q.stat_drv[1] && i_status[1] |=> o_status_oe_n[1])
      else $error("pin1 open-drain still drives high");
   pin0_od_a: assert property (
      s_q.stat_drv[0] && i_status[0] |=> o_status_oe_n[0])
      else $error("pin0 open-drain still drives high");
   push_pull_a: assert property (
      !s_q.stat_drv[0]
      |=> !o_status_oe_n[0] && o_status[0] == $past(i_status[0]))
      else $error("pin0 push-pull not driving");
   lvl_rb_a: assert property (
      i_wr && i_addr == `SPMLC_OFF_SIL_LVL_A ##1 i_rd
      && i_addr == `SPMLC_OFF_SIL_LVL_A |=> o_rdata == $past(i_wdata, 2))
      else $error("silence level readback mismatch");
   unmuted_run_a: assert property (
      !s_q.sil_ctrl[0] |=> o_out2_p == spmlc_pkg::SPMLC_DRV_RUN
      && o_out2_n == spmlc_pkg::SPMLC_DRV_RUN)
      else $error("out2 altered while not silenced");
   diff_three_a: assert property (
      s_q.sil_ctrl[1] && !i_out3_se && s_q.sil_lvl_a[7:6] == 2'h3
      |=> o_out3_p == spmlc_pkg::SPMLC_DRV_RAIL
      && o_out3_n == spmlc_pkg::SPMLC_DRV_LOW)
      else $error("out3 code 3 diff action wrong");
   se_one_a: assert property (
      s_q.sil_ctrl[0] && i_out2_se && s_q.sil_lvl_a[5:4] == 2'h1
      |=> o_out2_p == spmlc_pkg::SPMLC_DRV_RUN
      && o_out2_n == spmlc_pkg::SPMLC_DRV_LOW)
      else $error("out2 code 1 se action wrong");
   diff_two_a: assert property (
      s_q.sil_ctrl[0] && !i_out2_se && s_q.sil_lvl_a[5:4] == 2'h2
      |=> o_out2_p == spmlc_pkg::SPMLC_DRV_HIGH)
      else $error("out2 code 2 diff action wrong");

   // -----------------------------------------------------------------
   // register bus
   // -----------------------------------------------------------------
   // a read answers in the next cycle only, zero otherwise
   stat_rb_a: assert property (
      i_wr && i_addr == `SPMLC_OFF_STAT_DRV ##1 i_rd
      && i_addr == `SPMLC_OFF_STAT_DRV
      |=> o_rdata == ($past(i_wdata, 2) & `SPMLC_STAT_RW_MASK))
      else $error("status control readback mismatch");
   ctrl_rb_a: assert property (
      i_wr && i_addr == `SPMLC_OFF_SIL_CTRL ##1 i_rd
      && i_addr == `SPMLC_OFF_SIL_CTRL
      |=> o_rdata == {6'h00, $past(i_wdata[1:0], 2)})
      else $error("silence enable readback mismatch");
   stat_resvd_a: assert property (
      i_rd && i_addr == `SPMLC_OFF_STAT_DRV |=> o_rdata[7:6] == 2'h0)
      else $error("reserved status bits read nonzero");
   rd_idle_a: assert property (
      !i_rd |=> o_rdata == 8'h00)
      else $error("read data present without a read");
   rd_unmapped_a: assert property (
      i_rd && i_addr != `SPMLC_OFF_STAT_DRV
      && i_addr != `SPMLC_OFF_SIL_LVL_A && i_addr != `SPMLC_OFF_SIL_CTRL
      |=> o_rdata == 8'h00)
      else $error("unmapped address returned data");
   lvl_hold_a: assert property (
      !(i_wr && i_addr == `SPMLC_OFF_SIL_LVL_A)
      |=> s_q.sil_lvl_a == $past(s_q.sil_lvl_a))
      else $error("silence levels changed without a write");
   stat_hold_a: assert property (
      !(i_wr && i_addr == `SPMLC_OFF_STAT_DRV)
      |=> s_q.stat_drv == $past(s_q.stat_drv))
      else $error("status control changed without a write");
   ctrl_hold_a: assert property (
      !(i_wr && i_addr == `SPMLC_OFF_SIL_CTRL)
      |=> s_q.sil_ctrl == $past(s_q.sil_ctrl))
      else $error("silence enables changed without a write");
   spike_hold_a: assert property (
      !(i_wr && i_addr == `SPMLC_OFF_STAT_DRV) ##1 1'b1
      |=> $stable(o_status_spike_lim))
      else $error("spike limit moved without a write");

   // -----------------------------------------------------------------
   // status pins
   // -----------------------------------------------------------------
   // open-drain only ever releases a high; a low is always driven
   pin1_pp_a: assert property (
      !s_q.stat_drv[1]
      |=> !o_status_oe_n[1] && o_status[1] == $past(i_status[1]))
      else $error("pin1 push-pull not driving");
   pin0_od_low_a: assert property (
      s_q.stat_drv[0] && !i_status[0]
      |=> !o_status_oe_n[0] && !o_status[0])
      else $error("pin0 open-drain not pulling low");
   pin1_od_low_a: assert property (
      s_q.stat_drv[1] && !i_status[1]
      |=> !o_status_oe_n[1] && !o_status[1])
      else $error("pin1 open-drain not pulling low");
   pin_data_a: assert property (
      1'b1 |=> o_status == $past(i_status))
      else $error("pin data not following status");

   // -----------------------------------------------------------------
   // out2 silenced drive
   // -----------------------------------------------------------------
   // level codes only matter while the enable bit is set
   out2_bypass_a: assert property (
      s_q.sil_ctrl[0] && s_q.sil_lvl_a[5:4] == 2'h0
      |=> o_out2_p == spmlc_pkg::SPMLC_DRV_RUN
      && o_out2_n == spmlc_pkg::SPMLC_DRV_RUN)
      else $error("out2 bypass code altered the driver");
   out2_diff_one_a: assert property (
      s_q.sil_ctrl[0] && !i_out2_se && s_q.sil_lvl_a[5:4] == 2'h1
      |=> o_out2_p == spmlc_pkg::SPMLC_DRV_VCM
      && o_out2_n == spmlc_pkg::SPMLC_DRV_VCM)
      else $error("out2 code 1 diff action wrong");
   out2_diff_n_a: assert property (
      s_q.sil_ctrl[0] && !i_out2_se && s_q.sil_lvl_a[5:4] == 2'h2
      |=> o_out2_n == spmlc_pkg::SPMLC_DRV_HIGH)
      else $error("out2 code 2 diff n node wrong");
   out2_diff_three_a: assert property (
      s_q.sil_ctrl[0] && !i_out2_se && s_q.sil_lvl_a[5:4] == 2'h3
      |=> o_out2_p == spmlc_pkg::SPMLC_DRV_RAIL
      && o_out2_n == spmlc_pkg::SPMLC_DRV_LOW)
      else $error("out2 code 3 diff action wrong");
   out2_se_two_a: assert property (
      s_q.sil_ctrl[0] && i_out2_se && s_q.sil_lvl_a[5:4] == 2'h2
      |=> o_out2_p == spmlc_pkg::SPMLC_DRV_LOW
      && o_out2_n == spmlc_pkg::SPMLC_DRV_RUN)
      else $error("out2 code 2 se action wrong");
   out2_se_three_a: assert property (
      s_q.sil_ctrl[0] && i_out2_se && s_q.sil_lvl_a[5:4] == 2'h3
      |=> o_out2_p == spmlc_pkg::SPMLC_DRV_LOW
      && o_out2_n == spmlc_pkg::SPMLC_DRV_LOW)
      else $error("out2 code 3 se action wrong");

   // -----------------------------------------------------------------
   // out3 silenced drive
   // -----------------------------------------------------------------
   out3_unmuted_a: assert property (
      !s_q.sil_ctrl[1]
      |=> o_out3_p == spmlc_pkg::SPMLC_DRV_RUN
      && o_out3_n == spmlc_pkg::SPMLC_DRV_RUN)
      else $error("out3 altered while not silenced");
   out3_bypass_a: assert property (
      s_q.sil_ctrl[1] && s_q.sil_lvl_a[7:6] == 2'h0
      |=> o_out3_p == spmlc_pkg::SPMLC_DRV_RUN
      && o_out3_n == spmlc_pkg::SPMLC_DRV_RUN)
      else $error("out3 bypass code altered the driver");
   out3_diff_one_a: assert property (
      s_q.sil_ctrl[1] && !i_out3_se && s_q.sil_lvl_a[7:6] == 2'h1
      |=> o_out3_p == spmlc_pkg::SPMLC_DRV_VCM
      && o_out3_n == spmlc_pkg::SPMLC_DRV_VCM)
      else $error("out3 code 1 diff action wrong");
   out3_diff_two_a: assert property (
      s_q.sil_ctrl[1] && !i_out3_se && s_q.sil_lvl_a[7:6] == 2'h2
      |=> o_out3_p == spmlc_pkg::SPMLC_DRV_HIGH
      && o_out3_n == spmlc_pkg::SPMLC_DRV_HIGH)
      else $error("out3 code 2 diff action wrong");
   out3_se_one_a: assert property (
      s_q.sil_ctrl[1] && i_out3_se && s_q.sil_lvl_a[7:6] == 2'h1
      |=> o_out3_p == spmlc_pkg::SPMLC_DRV_RUN
      && o_out3_n == spmlc_pkg::SPMLC_DRV_LOW)
      else $error("out3 code 1 se action wrong");
   out3_se_two_a: assert property (
      s_q.sil_ctrl[1] && i_out3_se && s_q.sil_lvl_a[7:6] == 2'h2
      |=> o_out3_p == spmlc_pkg::SPMLC_DRV_LOW
      && o_out3_n == spmlc_pkg::SPMLC_DRV_RUN)
      else $error("out3 code 2 se action wrong");
   out3_se_three_a: assert property (
      s_q.sil_ctrl[1] && i_out3_se && s_q.sil_lvl_a[7:6] == 2'h3
      |=> o_out3_p == spmlc_pkg::SPMLC_DRV_LOW
      && o_out3_n == spmlc_pkg::SPMLC_DRV_LOW)
      else $error("out3 code 3 se action wrong");

   cover_od_c:    cover property (s_q.stat_drv[1:0] == 2'h3);
   cover_mute3_c: cover property (o_out3_p == spmlc_pkg::SPMLC_DRV_RAIL);
   cover_se2_c:   cover property (o_out2_p == spmlc_pkg::SPMLC_DRV_LOW);
   cover_vcm2_c:  cover property (o_out2_p == spmlc_pkg::SPMLC_DRV_VCM);
   cover_rd_c:    cover property (i_rd ##1 o_rdata != 8'h00);
endmodule

/* rtl/spmlc_consts.svh */
// register offsets, field positions, reset values for status/silence bank
`ifndef SPMLC_CONSTS_SVH
`define SPMLC_CONSTS_SVH
`define SPMLC_ADDR_W          8
`define SPMLC_OFF_STAT_DRV    8'h13
`define SPMLC_OFF_SIL_LVL_A   8'h14
`define SPMLC_OFF_SIL_CTRL    8'h15
`define SPMLC_BIT_P1_SPIKE    5
`define SPMLC_BIT_P0_SPIKE    4
`define SPMLC_BIT_P1_OD       1
`define SPMLC_BIT_P0_OD       0
`define SPMLC_STAT_RW_MASK    8'h3f
`define SPMLC_RST_STAT_DRV    8'h00
`define SPMLC_OUT3_LVL_HI     7
`define SPMLC_OUT3_LVL_LO     6
`define SPMLC_OUT2_LVL_HI     5
`define SPMLC_OUT2_LVL_LO     4
`define SPMLC_RST_SIL_LVL_A   8'h55
`define SPMLC_RST_SIL_CTRL    8'h00
`endif

/* rtl/spmlc_pkg.sv */
// types for the status pin and silence level bank
package spmlc_pkg;
   typedef enum logic [1:0] {
      SPMLC_LVL_BYPASS,
      SPMLC_LVL_ONE,
      SPMLC_LVL_TWO,
      SPMLC_LVL_THREE
   } spmlc_lvl_t;

   // driver action per node
   typedef enum logic [2:0] {
      SPMLC_DRV_RUN,
      SPMLC_DRV_LOW,
      SPMLC_DRV_HIGH,
      SPMLC_DRV_VCM,
      SPMLC_DRV_RAIL
   } spmlc_drv_t;

   typedef struct packed {
      logic [7:0] stat_drv;
      logic [7:0] sil_lvl_a;
      logic [7:0] sil_ctrl;
      logic [7:0] rdata;
      logic [1:0] st_o;
      logic [1:0] st_oe_n;
      logic [1:0] st_spike;
      logic [2:0] o2_p;
      logic [2:0] o2_n;
      logic [2:0] o3_p;
      logic [2:0] o3_n;
   } spmlc_state_t;
endpackage

/* sim/test_spmlc_bank.sv */
// self-checking bench for the status pin and silence level bank
`timescale 1ns/10ps
`include "spmlc_consts.svh"

module test_spmlc_bank;
   logic                        i_clock = 1'b0;
   logic                        i_nrst = 1'b0;
   logic [7:0]                  i_addr = 8'h00;
   logic [7:0]                  i_wdata = 8'h00;
   logic                        i_wr = 1'b0;
   logic                        i_rd = 1'b0;
   logic [1:0]                  i_status = 2'h2;
   logic                        i_out2_se = 1'b0;
   logic                        i_out3_se = 1'b0;
   logic [7:0]                  o_rdata;
   logic [1:0]                  o_status;
   logic [1:0]                  o_status_oe_n;
   logic [1:0]                  o_status_spike_lim;
   spmlc_pkg::spmlc_drv_t       o_out2_p, o_out2_n, o_out3_p, o_out3_n;
   int                          bad_count = 0;
   int                          comparisons = 0;
   logic [7:0]                  v;
   logic [7:0]                  e;

   spmlc_bank i_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_status(i_status), .i_out2_se(i_out2_se), .i_out3_se(i_out3_se),
      .o_status(o_status), .o_status_oe_n(o_status_oe_n),
      .o_status_spike_lim(o_status_spike_lim), .o_out2_p(o_out2_p),
      .o_out2_n(o_out2_n), .o_out3_p(o_out3_p), .o_out3_n(o_out3_n));

   always #2 i_clock = ~i_clock;

   task check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask

   // outputs lag the register by one more edge
   task settle;
      @(posedge i_clock);
      #1;
   endtask

   function automatic logic [5:0] pn(input logic s, input logic [1:0] l);
      case ({s, l})
         3'h1: pn = {spmlc_pkg::SPMLC_DRV_VCM, spmlc_pkg::SPMLC_DRV_VCM};
         3'h2: pn = {spmlc_pkg::SPMLC_DRV_HIGH, spmlc_pkg::SPMLC_DRV_HIGH};
         3'h3: pn = {spmlc_pkg::SPMLC_DRV_RAIL, spmlc_pkg::SPMLC_DRV_LOW};
         3'h5: pn = {spmlc_pkg::SPMLC_DRV_RUN, spmlc_pkg::SPMLC_DRV_LOW};
         3'h6: pn = {spmlc_pkg::SPMLC_DRV_LOW, spmlc_pkg::SPMLC_DRV_RUN};
         3'h7: pn = {spmlc_pkg::SPMLC_DRV_LOW, spmlc_pkg::SPMLC_DRV_LOW};
         default: pn = {spmlc_pkg::SPMLC_DRV_RUN, spmlc_pkg::SPMLC_DRV_RUN};
      endcase
   endfunction

   task reset_check;
      rd(`SPMLC_OFF_STAT_DRV, v);
      check(v, `SPMLC_RST_STAT_DRV);
      rd(`SPMLC_OFF_SIL_LVL_A, v);
      check(v, `SPMLC_RST_SIL_LVL_A);
      rd(`SPMLC_OFF_SIL_CTRL, v);
      check(v, `SPMLC_RST_SIL_CTRL);
      check({6'h00, o_status_spike_lim}, 8'h00);
   endtask

   task test_done;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge i_clock);
      i_nrst <= 1'b1;
      reset_check();
      $display("reset values done");
      // every code in both modes, out3 gets the mirrored code
      wr(`SPMLC_OFF_SIL_CTRL, 8'h03);
      for (int l = 0; l < 4; l++) begin
         for (int s = 0; s < 2; s++) begin
            @(posedge i_clock);
            i_out2_se <= s[0];
            i_out3_se <= ~s[0];
            wr(`SPMLC_OFF_SIL_LVL_A, {2'(3 - l), 2'(l), 4'h0});
            settle();
            e = {2'h0, pn(s[0], 2'(l))};
            check({2'h0, o_out2_p, o_out2_n}, e);
            e = {2'h0, pn(~s[0], 2'(3 - l))};
            check({2'h0, o_out3_p, o_out3_n}, e);
            rd(`SPMLC_OFF_SIL_LVL_A, v);
            check(v, {2'(3 - l), 2'(l), 4'h0});
         end
      end
      wr(`SPMLC_OFF_SIL_LVL_A, 8'hff);
      wr(`SPMLC_OFF_SIL_CTRL, 8'h02);
      settle();
      e = {2'h0, pn(1'b0, 2'h0)};
      check({2'h0, o_out2_p, o_out2_n}, e);
      e = {2'h0, pn(i_out3_se, 2'h3)};
      check({2'h0, o_out3_p, o_out3_n}, e);
      $display("silence levels done");
      // reserved bits 7:6 and 3:2 left zero
      wr(`SPMLC_OFF_STAT_DRV, 8'h33);
      rd(`SPMLC_OFF_STAT_DRV, v);
      check(v, 8'h33);
      check({6'h00, o_status_spike_lim}, 8'h03);
      check({7'h00, o_status_oe_n[1]}, 8'h01);
      check({6'h00, o_status[0], o_status_oe_n[0]}, 8'h00);
      @(posedge i_clock);
      i_status <= 2'h3;
      settle();
      check({6'h00, o_status_oe_n}, 8'h03);
      wr(`SPMLC_OFF_STAT_DRV, 8'h10);
      settle();
      check({4'h0, o_status, o_status_oe_n}, 8'h0c);
      check({6'h00, o_status_spike_lim}, 8'h01);
      wr(`SPMLC_OFF_STAT_DRV, 8'h20);
      settle();
      check({6'h00, o_status_spike_lim}, 8'h02);
      $display("status pins done");
      wr(8'h16, 8'haa);
      rd(8'h16, v);
      check(v, 8'h00);
      rd(`SPMLC_OFF_STAT_DRV, v);
      check(v, 8'h20);
      @(posedge i_clock);
      i_nrst <= 1'b0;
      repeat (8) @(posedge i_clock);
      i_nrst <= 1'b1;
      reset_check();
      $display("unmapped and second reset done");
      test_done();
   end
endmodule
